// file: inc/flash_id_map.svh
// Named constants for the identification and protection host controller.
`ifndef FLASH_ID_MAP_SVH
`define FLASH_ID_MAP_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define STROBE_NS 150
`define HV_SETTLE_NS 500
`define SYNC_STAGES 2

// ----------------------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------------------
`define SECTOR_LSB 15
`define SECTOR_W 6
`define CODE_W 4
`define CODE_SIX_BIT 6

// ----------------------------------------------------------------------------
// Code select values
// ----------------------------------------------------------------------------
`define CODE_MAKER 4'h0
`define CODE_VERIFY 4'h2
`define CODE_SECURED 4'h3

// ----------------------------------------------------------------------------
// Group layout of the uniform 32-megabit part
// ----------------------------------------------------------------------------
`define LOW_SINGLES 5'h04
`define MID_GROUPS_END 5'h12
`define GROUP_COUNT 5'h16
`define HIGH_FIRST_SECTOR 6'h3c
`define GROUP_SPAN_SHIFT 2

`endif

// file: inc/flash_id_pkg.sv
// Types shared by the identification host controller and its bus cycle engine.
package flash_id_pkg;

  // --------------------------------------------------------------------------
  // Operations that the user side may request
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ID_PIN,
    OP_ID_CMD,
    OP_VERIFY,
    OP_PROTECT,
    OP_UNPROTECT_ALL
  } op_e;

  // --------------------------------------------------------------------------
  // Which pin carries the elevated voltage
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    HV_NONE,
    HV_SELECT_PIN,
    HV_RESET_PIN
  } hv_e;

endpackage : flash_id_pkg

// file: logic/flash_id_host.sv
// Host controller that reads identifiers and manages group protection of a NOR flash.
`timescale 1ns/10ps
`include "flash_id_map.svh"

module flash_id_host #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16,
  parameter logic [ADDR_W-1:0] CMD_ADDR_0 = '0,
  parameter logic [ADDR_W-1:0] CMD_ADDR_1 = '0,
  parameter logic [ADDR_W-1:0] CMD_ADDR_2 = '0,
  parameter logic [DATA_W-1:0] CMD_DATA_0 = '0,
  parameter logic [DATA_W-1:0] CMD_DATA_1 = '0,
  parameter logic [DATA_W-1:0] CMD_DATA_2 = '0,
  parameter logic [DATA_W-1:0] EXIT_DATA = '0,
  parameter logic [DATA_W-1:0] PROTECT_DATA = '0,
  parameter logic [DATA_W-1:0] UNPROTECT_DATA = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req,
  input wire flash_id_pkg::op_e req_op,
  input wire logic [3:0] req_code,
  input wire logic [5:0] req_sector,
  output logic busy,
  output logic done,
  output logic [7:0] result_byte,
  output logic result_protected,
  output logic result_locked,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic select_hv_en,
  output logic reset_hv_en
);
  import flash_id_pkg::*;

  localparam int SETTLE_CYC = (`HV_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETTLE, ST_CMD, ST_READ, ST_VER, ST_PROT, ST_UNPROT, ST_EXIT, ST_DONE
  } st_e;

  st_e state_reg;
  st_e after_settle_reg;
  op_e op_reg;
  hv_e hv_reg;
  logic [3:0] code_reg;
  logic [5:0] sector_reg;
  logic [4:0] group_reg;
  logic [1:0] cmd_idx_reg;
  logic [7:0] settle_reg;
  logic issued_reg;
  logic sweep_done_reg;
  logic bus_start;
  logic bus_write;
  logic bus_done;
  logic bus_busy;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic [7:0] bus_rdata;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Builds an address from sector and code; every other bit is driven low.
  function automatic logic [ADDR_W-1:0] compose(input logic [5:0] sect, input logic [3:0] code);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[`SECTOR_LSB +: `SECTOR_W] = sect;
    a[`CODE_W-1:0] = code;
    a[`CODE_SIX_BIT] = 1'b0;
    return a;
  endfunction : compose

  // Maps a group index to the first sector of that group.
  function automatic logic [5:0] group_sector(input logic [4:0] g);
    logic [5:0] s;
    s = 6'h00;
    if (g < `LOW_SINGLES) begin
      s = {1'b0, g};
    end else if (g < `MID_GROUPS_END) begin
      s = 6'({g, 2'b00}) - 6'(`LOW_SINGLES * 3);
    end else begin
      s = `HIGH_FIRST_SECTOR + 6'(g - `MID_GROUPS_END);
    end
    return s;
  endfunction : group_sector

  // ----------------------------------------------------------------------------
  // Bus cycle engine
  // ----------------------------------------------------------------------------
  id_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
    .clk(clk),
    .resetn(resetn),
    .start(bus_start),
    .write(bus_write),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .rdata(bus_rdata),
    .done(bus_done),
    .busy(bus_busy),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in)
  );

  // Selects the cycle that the current state needs.
  always_comb begin
    bus_write = 1'b0;
    bus_addr = compose(sector_reg, code_reg);
    bus_wdata = '0;
    case (state_reg)
      ST_CMD: begin
        bus_write = 1'b1;
        bus_addr = (cmd_idx_reg == 2'd0) ? CMD_ADDR_0 : (cmd_idx_reg == 2'd1) ? CMD_ADDR_1 : CMD_ADDR_2;
        bus_wdata = (cmd_idx_reg == 2'd0) ? CMD_DATA_0 : (cmd_idx_reg == 2'd1) ? CMD_DATA_1 : CMD_DATA_2;
      end
      ST_VER: begin
        bus_addr = compose(group_sector(group_reg), `CODE_VERIFY);
      end
      ST_PROT: begin
        bus_write = 1'b1;
        bus_addr = compose(sector_reg, `CODE_MAKER);
        bus_wdata = PROTECT_DATA;
      end
      ST_UNPROT: begin
        bus_write = 1'b1;
        bus_addr = compose(6'h00, `CODE_MAKER);
        bus_wdata = UNPROTECT_DATA;
      end
      ST_EXIT: begin
        bus_write = 1'b1;
        bus_addr = '0;
        bus_wdata = EXIT_DATA;
      end
      default: begin
      end
    endcase
  end

  // One cycle is started per visit to a cycle state; ST_CMD starts one for each of its three command writes.
  assign bus_start = !issued_reg && !bus_busy &&
                     (state_reg == ST_CMD || state_reg == ST_READ || state_reg == ST_VER ||
                      state_reg == ST_PROT || state_reg == ST_UNPROT || state_reg == ST_EXIT);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      issued_reg <= 1'b0;
    end else if (bus_done) begin
      issued_reg <= 1'b0;
    end else if (bus_start) begin
      issued_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------------------
  // The elevated voltage changes only on entry to ST_SETTLE, which then waits for it to settle, and drops on leaving ST_DONE.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      after_settle_reg <= ST_IDLE;
      op_reg <= OP_ID_PIN;
      hv_reg <= HV_NONE;
      code_reg <= 4'h0;
      sector_reg <= 6'h00;
      group_reg <= 5'h00;
      cmd_idx_reg <= 2'd0;
      settle_reg <= 8'h00;
      sweep_done_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sweep_done_reg <= 1'b0;
          if (req) begin
            op_reg <= req_op;
            code_reg <= req_code;
            sector_reg <= req_sector;
            group_reg <= 5'h00;
            cmd_idx_reg <= 2'd0;
            settle_reg <= 8'h00;
            state_reg <= ST_SETTLE;
            case (req_op)
              OP_ID_CMD: begin
                hv_reg <= HV_NONE;
                after_settle_reg <= ST_CMD;
              end
              OP_PROTECT: begin
                hv_reg <= HV_RESET_PIN;
                after_settle_reg <= ST_PROT;
              end
              OP_UNPROTECT_ALL: begin
                hv_reg <= HV_SELECT_PIN;
                after_settle_reg <= ST_VER;
              end
              OP_VERIFY: begin
                hv_reg <= HV_SELECT_PIN;
                code_reg <= `CODE_VERIFY;
                after_settle_reg <= ST_READ;
              end
              default: begin
                hv_reg <= HV_SELECT_PIN;
                after_settle_reg <= ST_READ;
              end
            endcase
          end
        end
        ST_SETTLE: begin
          settle_reg <= settle_reg + 8'h01;
          if (settle_reg == 8'(SETTLE_CYC - 1)) begin
            state_reg <= after_settle_reg;
          end
        end
        ST_CMD: begin
          if (bus_done) begin
            cmd_idx_reg <= cmd_idx_reg + 2'd1;
            if (cmd_idx_reg == 2'd2) begin
              state_reg <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (bus_done) begin
            state_reg <= (op_reg == OP_ID_CMD) ? ST_EXIT : ST_DONE;
          end
        end
        ST_VER: begin
          if (bus_done) begin
            sector_reg <= group_sector(group_reg);
            settle_reg <= 8'h00;
            state_reg <= ST_SETTLE;
            if (!bus_rdata[0]) begin
              hv_reg <= HV_RESET_PIN;
              after_settle_reg <= ST_PROT;
            end else if (group_reg == `GROUP_COUNT - 5'h01) begin
              sweep_done_reg <= 1'b1;
              hv_reg <= HV_RESET_PIN;
              after_settle_reg <= ST_UNPROT;
            end else begin
              group_reg <= group_reg + 5'h01;
              after_settle_reg <= ST_VER;
            end
          end
        end
        ST_PROT: begin
          if (bus_done) begin
            settle_reg <= 8'h00;
            if (op_reg != OP_UNPROTECT_ALL) begin
              state_reg <= ST_DONE;
            end else if (group_reg == `GROUP_COUNT - 5'h01) begin
              sweep_done_reg <= 1'b1;
              state_reg <= ST_UNPROT;
            end else begin
              group_reg <= group_reg + 5'h01;
              hv_reg <= HV_SELECT_PIN;
              after_settle_reg <= ST_VER;
              state_reg <= ST_SETTLE;
            end
          end
        end
        ST_UNPROT, ST_EXIT: begin
          if (bus_done) begin
            state_reg <= ST_DONE;
          end
        end
        default: begin
          hv_reg <= HV_NONE;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Result byte is taken from the identifier read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_byte <= 8'h00;
    end else if (state_reg == ST_READ && bus_done) begin
      result_byte <= bus_rdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign select_hv_en = (hv_reg == HV_SELECT_PIN);
  assign reset_hv_en = (hv_reg == HV_RESET_PIN);
  assign busy = (state_reg != ST_IDLE);
  assign done = (state_reg == ST_DONE);
  assign result_protected = result_byte[0];
  // Both guard variants report the factory lock in bit seven.
  assign result_locked = result_byte[7];

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_hv_during_read: assert property (!flash_oe_n && op_reg != OP_ID_CMD |-> select_hv_en)
    else $error("Select pin voltage missing during an identifier read.");
  chk_bit_six_low: assert property (!flash_ce_n && select_hv_en |-> !flash_addr[`CODE_SIX_BIT])
    else $error("Code select bit six high during identification.");
  chk_code_bits: assert property (state_reg == ST_READ && !flash_oe_n |-> flash_addr[3:0] == code_reg)
    else $error("Code select bits do not match the request.");
  chk_sector_on_top: assert property (state_reg == ST_VER && !flash_oe_n
      |-> flash_addr[`SECTOR_LSB +: `SECTOR_W] == group_sector(group_reg))
    else $error("Sector address missing from a protection read.");
  chk_cmd_no_hv: assert property (op_reg == OP_ID_CMD && busy |-> !select_hv_en && !reset_hv_en)
    else $error("Elevated voltage applied in command method.");
  chk_reset_pin_only: assert property (!flash_we_n && (state_reg == ST_PROT || state_reg == ST_UNPROT)
      |-> reset_hv_en && !select_hv_en)
    else $error("Protect write without reset pin voltage.");
  chk_strobes_apart: assert property (!(!flash_oe_n && !flash_we_n)
      && (!flash_ce_n || (flash_oe_n && flash_we_n)))
    else $error("Bus strobes overlap or lack chip select.");
  chk_sweep_first: assert property ($fell(flash_we_n) && state_reg == ST_UNPROT |-> sweep_done_reg)
    else $error("Unprotect write before all groups were protected.");
  chk_dontcare_low: assert property (!flash_oe_n && select_hv_en
      |-> flash_addr[`SECTOR_LSB-1:`CODE_SIX_BIT+1] == '0 && flash_addr[5:4] == 2'b00)
    else $error("Ignored address bits not driven low.");
  chk_settle_wait: assert property ($rose(select_hv_en) |-> flash_ce_n [*8])
    else $error("Bus cycle before the select voltage settled.");

  cov_pin_read: cover property (state_reg == ST_READ && bus_done && op_reg == OP_ID_PIN);
  cov_cmd_read: cover property (state_reg == ST_EXIT && bus_done);
  cov_sweep_protect: cover property (state_reg == ST_PROT && bus_done && op_reg == OP_UNPROTECT_ALL);
  cov_unprotect: cover property (state_reg == ST_UNPROT && bus_done);

endmodule : flash_id_host

// file: logic/id_bus_cycle.sv
// One asynchronous read or write cycle on the flash pins.
`timescale 1ns/10ps
`include "flash_id_map.svh"
module id_bus_cycle #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [7:0] rdata,
  output logic done,
  output logic busy,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [DATA_W-1:0] flash_dq_in
);
  import flash_id_pkg::*;

  localparam int STROBE_CYC = (`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int READ_CYC = STROBE_CYC + `SYNC_STAGES;

  typedef enum logic [1:0] {BC_IDLE, BC_STROBE, BC_HOLD, BC_GAP} bc_state_e;

  bc_state_e state_reg;
  logic write_reg;
  logic [3:0] cnt_reg;
  logic [7:0] dq_meta_reg;
  logic [7:0] dq_sync_reg;

  // ----------------------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------------------
  // Two stages on the low data byte; only the second stage is read below.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_meta_reg <= 8'h00;
      dq_sync_reg <= 8'h00;
    end else begin
      dq_meta_reg <= flash_dq_in[7:0];
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------------------
  // Reads keep the strobe low long enough for the synchroniser to catch up.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= BC_IDLE;
      write_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        BC_IDLE: begin
          if (start) begin
            state_reg <= BC_STROBE;
            write_reg <= write;
            cnt_reg <= 4'h1;
          end
        end
        BC_STROBE: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (write_reg && cnt_reg == 4'(STROBE_CYC)) begin
            state_reg <= BC_HOLD;
          end else if (!write_reg && cnt_reg == 4'(READ_CYC)) begin
            state_reg <= BC_GAP;
          end
        end
        BC_HOLD: begin
          state_reg <= BC_GAP;
        end
        default: begin
          state_reg <= BC_IDLE;
        end
      endcase
    end
  end

  // Address and write data are latched at the start and held for the cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flash_addr <= '0;
      flash_dq_out <= '0;
    end else if (state_reg == BC_IDLE && start) begin
      flash_addr <= addr;
      flash_dq_out <= wdata;
    end
  end

  // Read data is captured from the synchroniser at the end of the strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (state_reg == BC_STROBE && !write_reg && cnt_reg == 4'(READ_CYC)) begin
      rdata <= dq_sync_reg;
    end
  end

  // Pin strobes follow the sequencer state.
  assign flash_ce_n = (state_reg == BC_IDLE) || (state_reg == BC_GAP);
  assign flash_oe_n = !(state_reg == BC_STROBE && !write_reg);
  assign flash_we_n = !(state_reg == BC_STROBE && write_reg);
  assign flash_dq_oe = write_reg && (state_reg == BC_STROBE || state_reg == BC_HOLD);
  assign done = (state_reg == BC_GAP);
  assign busy = (state_reg != BC_IDLE);

endmodule : id_bus_cycle

// file: sim/flash_id_model.sv
// Behavioural model of the flash device seen by the identification host.
`timescale 1ns/10ps
module flash_id_model #(
  parameter int DLY_NS = 120,
  // Identity values are arbitrary.
  parameter logic [7:0] MAKER = 8'h5a,
  parameter logic [7:0] DEV1 = 8'h61,
  parameter logic [7:0] DEV2 = 8'h62,
  parameter logic [7:0] DEV3 = 8'h63,
  parameter logic [20:0] CA0 = 21'h000111,
  parameter logic [20:0] CA1 = 21'h000222,
  parameter logic [15:0] CD0 = 16'h00c1,
  parameter logic [15:0] CD1 = 16'h00c2,
  parameter logic [15:0] CD2 = 16'h00c3,
  parameter logic [15:0] EXIT_D = 16'h00c4,
  parameter logic [15:0] PROT_D = 16'h00a1,
  parameter logic [15:0] UNPROT_D = 16'h00a2
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_w,
  output wire logic [15:0] dq_r,
  input wire logic select_hv,
  input wire logic reset_hv,
  input wire logic wp_top,
  input wire logic locked,
  output logic fault
);
  logic [21:0] prot_reg = '0;
  logic id_cmd = 1'b0;
  int step = 0;
  logic [7:0] byte_now;
  logic [15:0] last_q = '0;

  // Four low and four high sectors stand alone, the rest go by fours.
  function automatic int grp(input logic [5:0] s);
    if (s < 6'h04) return int'(s);
    if (s >= 6'h3c) return int'(s) - 42;
    return 4 + (int'(s) - 4) / 4;
  endfunction : grp

  // Only the select, code and sector bits choose the byte.
  always_comb begin
    byte_now = 8'hff;
    if ((select_hv || id_cmd) && !addr[6]) begin
      case (addr[3:0])
        4'h0: byte_now = MAKER;
        4'h1: byte_now = DEV1;
        4'he: byte_now = DEV2;
        4'hf: byte_now = DEV3;
        4'h2: byte_now = {7'h00, prot_reg[grp(addr[20:15])]};
        4'h3: byte_now = {locked, 2'b00, wp_top, 4'h8};
        default: byte_now = 8'hff;
      endcase
    end
  end

  // A released bus shows the inverse of the last driven value.
  always @(byte_now or oe_n or ce_n) begin
    if (!ce_n && !oe_n) last_q = {8'h00, byte_now};
  end
  assign #(DLY_NS) dq_r = (!ce_n && !oe_n) ? {8'h00, byte_now} : ~last_q;

  // Reads with no identification path open are misuse.
  always @(negedge oe_n) begin
    if (!ce_n && !select_hv && !id_cmd) fault = 1'b1;
  end

  // Writes are taken well inside the low phase of the write strobe.
  initial fault = 1'b0;
  always @(negedge we_n) begin
    #20;
    if (reset_hv && !select_hv) begin
      if (dq_w === PROT_D) prot_reg[grp(addr[20:15])] = 1'b1;
      else if (dq_w === UNPROT_D) begin
        if (!(&prot_reg)) fault = 1'b1;
        prot_reg = '0;
      end
    end else if (select_hv || reset_hv) fault = 1'b1;
    else if (dq_w === EXIT_D) id_cmd = 1'b0;
    else if (step == 0 && addr === CA0 && dq_w === CD0) step = 1;
    else if (step == 1 && addr === CA1 && dq_w === CD1) step = 2;
    else if (step == 2 && addr === CA0 && dq_w === CD2) id_cmd = 1'b1;
    else step = 0;
    if (id_cmd) step = 0;
  end
endmodule : flash_id_model

// file: sim/tb.sv
// Self-checking testbench of the identification host against the flash model.
`timescale 1ns/10ps
module tb;
  import flash_id_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  op_e req_op = OP_ID_PIN;
  logic [3:0] req_code = 4'h0;
  logic [5:0] req_sector = 6'h00;
  logic busy, done, rprot, rlock, ce_n, oe_n, we_n, dq_oe, shv, rhv, fault;
  logic [7:0] rbyte;
  logic [20:0] faddr;
  logic [15:0] dq_o, dq_i;
  logic wp_top = 1'b0;
  logic locked = 1'b0;
  logic hv_in_cmd = 1'b0;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  // Command and protection codes; they match the flash model's defaults.
  localparam logic [20:0] CA0 = 21'h000111;
  localparam logic [20:0] CA1 = 21'h000222;
  localparam logic [15:0] CD0 = 16'h00c1;
  localparam logic [15:0] CD1 = 16'h00c2;
  localparam logic [15:0] CD2 = 16'h00c3;
  localparam logic [15:0] EXIT_D = 16'h00c4;
  localparam logic [15:0] PROT_D = 16'h00a1;
  localparam logic [15:0] UNPROT_D = 16'h00a2;

  flash_id_host #(.CMD_ADDR_0(CA0), .CMD_ADDR_1(CA1), .CMD_ADDR_2(CA0), .CMD_DATA_0(CD0),
    .CMD_DATA_1(CD1), .CMD_DATA_2(CD2), .EXIT_DATA(EXIT_D), .PROTECT_DATA(PROT_D),
    .UNPROTECT_DATA(UNPROT_D)) u_dut (.clk(clk), .resetn(resetn),
    .req(req), .req_op(req_op), .req_code(req_code), .req_sector(req_sector), .busy(busy),
    .done(done), .result_byte(rbyte), .result_protected(rprot), .result_locked(rlock),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
    .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_dq_in(dq_i), .select_hv_en(shv),
    .reset_hv_en(rhv));

  // Write data reaches the model only while the host enables its drivers.
  flash_id_model u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr),
    .dq_w(dq_oe ? dq_o : ~dq_o), .dq_r(dq_i), .select_hv(shv), .reset_hv(rhv), .wp_top(wp_top),
    .locked(locked), .fault(fault));

  // The command path must never raise the select pin voltage.
  always @(negedge clk) begin
    if (busy === 1'b1 && req_op == OP_ID_CMD && shv !== 1'b0) hv_in_cmd = 1'b1;
  end

  // Cycle ceiling that cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Issues one request and waits for its completion pulse.
  task automatic run(input op_e op, input logic [3:0] code, input logic [5:0] sec);
    int n;
    n = 0;
    req_op <= op;
    req_code <= code;
    req_sector <= sec;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check("done", 8'h01, {7'h00, n < 4000});
    @(posedge clk);
  endtask : run

  task automatic t_pin_codes();
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'he, 4'hf};
    logic [7:0] exp [4] = '{8'h5a, 8'h61, 8'h62, 8'h63};
    for (int i = 0; i < 4; i++) begin
      run(OP_ID_PIN, codes[i], 6'h2a);
      check("id byte", exp[i], rbyte);
    end
    @(negedge clk);
    check("hv dropped", 8'h00, {7'h00, shv});
    check("idle busy", 8'h00, {7'h00, busy});
    @(posedge clk);
    $display("test pin codes done");
  endtask : t_pin_codes

  task automatic t_secured();
    logic [7:0] exp [4] = '{8'h18, 8'h98, 8'h08, 8'h88};
    for (int i = 0; i < 4; i++) begin
      wp_top <= (i < 2);
      locked <= i[0];
      run(OP_ID_PIN, 4'h3, 6'h00);
      check("secured", exp[i], rbyte);
      check("locked", {7'h00, i[0]}, {7'h00, rlock});
    end
    $display("test secured done");
  endtask : t_secured

  task automatic t_protect();
    logic [5:0] secs [5] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h03};
    logic [7:0] exp [5] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    run(OP_VERIFY, 4'h0, 6'h05);
    check("fresh group", 8'h00, {7'h00, rprot});
    run(OP_PROTECT, 4'h0, 6'h04);
    for (int i = 0; i < 5; i++) begin
      run(OP_VERIFY, 4'h0, secs[i]);
      check("group state", exp[i], {7'h00, rprot});
    end
    run(OP_PROTECT, 4'h0, 6'h3f);
    run(OP_VERIFY, 4'h0, 6'h3e);
    check("top single", 8'h00, {7'h00, rprot});
    $display("test protect done");
  endtask : t_protect

  task automatic t_unprotect();
    logic [5:0] secs [4] = '{6'h00, 6'h05, 6'h20, 6'h3f};
    run(OP_UNPROTECT_ALL, 4'h0, 6'h00);
    check("order", 8'h00, {7'h00, fault});
    for (int i = 0; i < 4; i++) begin
      run(OP_VERIFY, 4'h0, secs[i]);
      check("cleared", 8'h00, {7'h00, rprot});
    end
    $display("test unprotect done");
  endtask : t_unprotect

  task automatic t_cmd_and_busy();
    req_op <= OP_ID_CMD;
    req_code <= 4'h1;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
    check("busy", 8'h01, {7'h00, busy});
    req_op <= OP_PROTECT;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    run(OP_ID_CMD, 4'h1, 6'h00);
    check("cmd id", 8'h61, rbyte);
    check("cmd hv", 8'h00, {7'h00, hv_in_cmd});
    run(OP_ID_PIN, 4'h0, 6'h00);
    check("after exit", 8'h5a, rbyte);
    check("no misuse", 8'h00, {7'h00, fault});
    run(OP_VERIFY, 4'h0, 6'h3f);
    check("refused", 8'h00, {7'h00, rprot});
    $display("test command path done");
  endtask : t_cmd_and_busy

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("idle strobes", 8'h07, {5'h00, ce_n, oe_n, we_n});
    check("idle hv", 8'h00, {6'h00, shv, rhv});
    t_pin_codes();
    t_secured();
    t_protect();
    t_unprotect();
    t_cmd_and_busy();
    end_of_test();
  end
endmodule : tb
